// [rtl/axis_cmd_pkg.sv]
// Constants shared by the axis command port and its general-purpose port latch.
// Assumes one reference clock paces every wait interval.
package axis_cmd_pkg;
  // Host bus addresses.
  localparam logic [2:0] ADDR_CMD = 3'h0;
  localparam logic [2:0] ADDR_GPPORT = 3'h2;
  localparam logic [2:0] ADDR_BUF0 = 3'h4;

  // Command codes.
  localparam logic [7:0] CODE_RD_EXEC_FIRST = 8'hD0;
  localparam logic [7:0] CODE_RD_EXEC_LAST = 8'hF6;
  localparam logic [7:0] CODE_RD_STEP = 8'hFC;
  localparam logic [7:0] CODE_RD_IPSTS = 8'hFF;
  localparam logic [7:0] CODE_WR_EXEC_FIRST = 8'h90;
  localparam logic [7:0] CODE_WR_EXEC_LAST = 8'hAC;
  localparam logic [7:0] CODE_WR_STEP = 8'hBC;
  localparam logic [7:0] CODE_RD_PRE_FIRST = 8'hC0;
  localparam logic [7:0] CODE_RD_PRE_LAST = 8'hCB;
  localparam logic [7:0] CODE_RD_PRE_STEP = 8'hCC;
  localparam logic [7:0] CODE_WR_PRE_FIRST = 8'h80;
  localparam logic [7:0] CODE_WR_PRE_LAST = 8'h8B;
  localparam logic [7:0] CODE_WR_PRE_STEP = 8'h8C;
  localparam logic [7:0] CODE_BIT_CLR_FIRST = 8'h10;
  localparam logic [7:0] CODE_BIT_SET_FIRST = 8'h18;
  localparam logic [7:0] CODE_BIT_LAST = 8'h1F;

  // Storage layout: writable execution registers, then the read-only group.
  localparam int WR_COUNT = 30;
  localparam int RO_COUNT = 11;
  localparam int PRE_COUNT = 13;
  localparam logic [5:0] IDX_RO_FIRST = 6'h1D;
  localparam logic [5:0] IDX_STEP = 6'h27;
  localparam logic [5:0] IDX_IPSTS = 6'h28;
  localparam logic [4:0] WR_IDX_STEP = 5'h1D;
  localparam logic [3:0] RO_IDX_IPSTS = 4'hA;
  localparam logic [3:0] PRE_IDX_STEP = 4'hC;
  localparam logic [4:0] IDX_PORT_CONFIG = 5'h0D;

  // Two mode bits per pin in the port configuration register.
  localparam int PIN_MODE_BITS = 2;
  localparam logic [1:0] PIN_MODE_OUTPUT = 2'h1;

  // Wait intervals in reference clock cycles.
  localparam int CMD_WAIT_CYCLES = 4;
  localparam int PORT_WAIT_CYCLES = 2;
  localparam logic [2:0] WAIT_ZERO = 3'h0;
  localparam logic [2:0] WAIT_ONE = 3'h1;
endpackage

// [rtl/gp_port_latch.sv]
// General-purpose pin latch shared by group writes and single-pin commands.
// Assumes pin inputs are asynchronous and mode bits come from the same clock.
module gp_port_latch #(
  parameter int PIN_COUNT = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic [PIN_COUNT*axis_cmd_pkg::PIN_MODE_BITS-1:0] pinMode,
  input wire logic groupWrite,
  input wire logic [PIN_COUNT-1:0] groupData,
  input wire logic bitWrite,
  input wire logic [2:0] bitIndex,
  input wire logic bitValue,
  input wire logic [PIN_COUNT-1:0] gpPinIn,
  output logic [PIN_COUNT-1:0] gpPinOut,
  output logic [PIN_COUNT-1:0] gpPinOe_n,
  output logic [PIN_COUNT-1:0] pinState
);
  if (PIN_COUNT < 1 || PIN_COUNT > 8) begin : badPinCount
    $error("PIN_COUNT must lie between 1 and 8");
  end

  logic [PIN_COUNT-1:0] pinSyncA_q;
  logic [PIN_COUNT-1:0] pinSyncB_q;
  logic [PIN_COUNT-1:0] latch_d;
  logic [PIN_COUNT-1:0] oe_d;
  logic [PIN_COUNT-1:0] state_d;

  for (genvar i = 0; i < PIN_COUNT; i++) begin : perPin
    logic isOut;
    assign isOut = pinMode[i*axis_cmd_pkg::PIN_MODE_BITS +: axis_cmd_pkg::PIN_MODE_BITS]
                   == axis_cmd_pkg::PIN_MODE_OUTPUT;
    always_comb begin
      latch_d[i] = gpPinOut[i];
      // Non-output pins ignore both paths, so the held value survives a direction change.
      if (isOut && groupWrite) begin
        latch_d[i] = groupData[i];
      end else if (isOut && bitWrite && bitIndex == 3'(i)) begin
        latch_d[i] = bitValue;
      end
      oe_d[i] = ~isOut;
      state_d[i] = isOut ? gpPinOut[i] : pinSyncB_q[i];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pinSyncA_q <= '0;
      pinSyncB_q <= '0;
      gpPinOut <= '0;
      gpPinOe_n <= '1;
      pinState <= '0;
    end else if (clkEn) begin
      pinSyncA_q <= gpPinIn;
      pinSyncB_q <= pinSyncA_q;
      gpPinOut <= latch_d;
      gpPinOe_n <= oe_d;
      pinState <= state_d;
    end
  end
endmodule

// [rtl/axis_register_command_port.sv]
// Command decoder for one axis: register copies through the I/O buffer and
// the general-purpose output port. Assumes host strobes and address/data are
// asynchronous pins held stable across the strobe; read-only values come
// from motion logic on the same clock.
//
// Contract
// - Read codes copy register into I/O buffer.
// - Write codes load register from I/O buffer.
// - Second pre-registers use their own codes.
// - Latched, status, monitor registers are read-only.
// - Port write sets all output-mode pins together.
// - High byte of port write ignored.
// - Pin latch kept after direction change.
// - Bit commands share the group latch.
// - Port configuration selects pin role.
// - Address two read returns pin state.
// - Port write holds wait request two cycles.
// - Commands spaced four cycles, wait request shown.
module axis_register_command_port #(
  parameter int CMD_WAIT = axis_cmd_pkg::CMD_WAIT_CYCLES,
  parameter int PORT_WAIT = axis_cmd_pkg::PORT_WAIT_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic [2:0] busAddr,
  input wire logic [15:0] busWrData,
  input wire logic busWrite_n,
  input wire logic busRead_n,
  output logic [7:0] busRdData,
  output logic waitRequest_n,
  input wire logic [axis_cmd_pkg::RO_COUNT*32-1:0] readOnlyValues,
  input wire logic [7:0] gpPinIn,
  output logic [7:0] gpPinOut,
  output logic [7:0] gpPinOe_n
);
  if (CMD_WAIT < 1 || CMD_WAIT > 7 || PORT_WAIT < 1 || PORT_WAIT > 7) begin : badWait
    $error("Wait counts must lie between 1 and 7");
  end

  localparam int SYNC_W = 21;

  // Bus pin synchronisers and strobe edge detection.
  // Address and data pass through the same two stages as the strobe, so they
  // line up with the edge that takes the write and never arrive half settled.
  logic [SYNC_W-1:0] syncA_q;
  logic [SYNC_W-1:0] syncB_q;
  logic prevWrite_n_q;
  logic [2:0] sAddr;
  logic [15:0] sData;
  logic sWrite_n;
  logic sRead_n;
  logic writeEvent;

  assign {sAddr, sData, sWrite_n, sRead_n} = syncB_q;
  assign writeEvent = prevWrite_n_q && !sWrite_n;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      syncA_q <= {3'h0, 16'h0000, 2'h3};
      syncB_q <= {3'h0, 16'h0000, 2'h3};
      prevWrite_n_q <= 1'b1;
    end else if (clkEn) begin
      syncA_q <= {busAddr, busWrData, busWrite_n, busRead_n};
      syncB_q <= syncA_q;
      prevWrite_n_q <= sWrite_n;
    end
  end

  // Register storage and command execution.
  // Every register keeps all 32 bits; trimming to field widths is left to the
  // motion logic that reads them, which costs flops but keeps the decode simple.
  logic [31:0] wrRegs_q [axis_cmd_pkg::WR_COUNT];
  logic [31:0] wrRegs_d [axis_cmd_pkg::WR_COUNT];
  logic [31:0] preRegs_q [axis_cmd_pkg::PRE_COUNT];
  logic [31:0] preRegs_d [axis_cmd_pkg::PRE_COUNT];
  logic [31:0] ioBuf_q;
  logic [31:0] ioBuf_d;
  logic [2:0] waitCnt_q;
  logic [2:0] waitCnt_d;
  logic groupWrite;
  logic bitWrite;
  logic [2:0] bitIndex;
  logic bitValue;
  logic [7:0] pinState;

  // Read-only words arrive as one flat bus from logic on this clock and are
  // sampled only on the edge that takes the read command.
  function automatic logic [31:0] readExec(input logic [5:0] idx,
                                           input logic [31:0] regs [axis_cmd_pkg::WR_COUNT],
                                           input logic [axis_cmd_pkg::RO_COUNT*32-1:0] ro);
    logic [31:0] value;
    value = 32'h0000_0000;
    if (idx < axis_cmd_pkg::IDX_RO_FIRST) begin
      value = regs[5'(idx)];
    end else if (idx < axis_cmd_pkg::IDX_STEP) begin
      value = ro[32*(idx - axis_cmd_pkg::IDX_RO_FIRST) +: 32];
    end else if (idx == axis_cmd_pkg::IDX_STEP) begin
      value = regs[axis_cmd_pkg::WR_IDX_STEP];
    end else begin
      value = ro[32*axis_cmd_pkg::RO_IDX_IPSTS +: 32];
    end
    return value;
  endfunction

  always_comb begin
    logic [7:0] code;
    code = sData[7:0];
    wrRegs_d = wrRegs_q;
    preRegs_d = preRegs_q;
    ioBuf_d = ioBuf_q;
    groupWrite = 1'b0;
    bitWrite = 1'b0;
    bitIndex = code[2:0];
    bitValue = 1'b0;
    // Writes during a wait are not blocked; a new command simply restarts the
    // count, so keeping commands apart remains the host's duty.
    waitCnt_d = (waitCnt_q == axis_cmd_pkg::WAIT_ZERO) ? waitCnt_q
                                                        : waitCnt_q - axis_cmd_pkg::WAIT_ONE;
    if (writeEvent) begin
      if (sAddr == axis_cmd_pkg::ADDR_CMD) begin
        waitCnt_d = 3'(CMD_WAIT);
        if (code >= axis_cmd_pkg::CODE_RD_EXEC_FIRST && code <= axis_cmd_pkg::CODE_RD_EXEC_LAST) begin
          ioBuf_d = readExec(6'(code - axis_cmd_pkg::CODE_RD_EXEC_FIRST), wrRegs_q,
                             readOnlyValues);
        end else if (code == axis_cmd_pkg::CODE_RD_STEP) begin
          ioBuf_d = readExec(axis_cmd_pkg::IDX_STEP, wrRegs_q, readOnlyValues);
        end else if (code == axis_cmd_pkg::CODE_RD_IPSTS) begin
          ioBuf_d = readExec(axis_cmd_pkg::IDX_IPSTS, wrRegs_q, readOnlyValues);
        end else if (code >= axis_cmd_pkg::CODE_WR_EXEC_FIRST &&
                     code <= axis_cmd_pkg::CODE_WR_EXEC_LAST) begin
          wrRegs_d[5'(code - axis_cmd_pkg::CODE_WR_EXEC_FIRST)] = ioBuf_q;
        end else if (code == axis_cmd_pkg::CODE_WR_STEP) begin
          wrRegs_d[axis_cmd_pkg::WR_IDX_STEP] = ioBuf_q;
        end else if (code >= axis_cmd_pkg::CODE_RD_PRE_FIRST &&
                     code <= axis_cmd_pkg::CODE_RD_PRE_LAST) begin
          ioBuf_d = preRegs_q[4'(code - axis_cmd_pkg::CODE_RD_PRE_FIRST)];
        end else if (code == axis_cmd_pkg::CODE_RD_PRE_STEP) begin
          ioBuf_d = preRegs_q[axis_cmd_pkg::PRE_IDX_STEP];
        end else if (code >= axis_cmd_pkg::CODE_WR_PRE_FIRST &&
                     code <= axis_cmd_pkg::CODE_WR_PRE_LAST) begin
          preRegs_d[4'(code - axis_cmd_pkg::CODE_WR_PRE_FIRST)] = ioBuf_q;
        end else if (code == axis_cmd_pkg::CODE_WR_PRE_STEP) begin
          preRegs_d[axis_cmd_pkg::PRE_IDX_STEP] = ioBuf_q;
        end else if (code >= axis_cmd_pkg::CODE_BIT_CLR_FIRST &&
                     code <= axis_cmd_pkg::CODE_BIT_LAST) begin
          bitWrite = 1'b1;
          bitValue = code >= axis_cmd_pkg::CODE_BIT_SET_FIRST;
        end
        // Any other code falls through with all storage untouched.
      end else if (sAddr == axis_cmd_pkg::ADDR_GPPORT) begin
        groupWrite = 1'b1;
        waitCnt_d = 3'(PORT_WAIT);
      end else if (sAddr >= axis_cmd_pkg::ADDR_BUF0) begin
        ioBuf_d[8*(sAddr - axis_cmd_pkg::ADDR_BUF0) +: 8] = sData[7:0];
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < axis_cmd_pkg::WR_COUNT; i++) begin
        wrRegs_q[i] <= 32'h0000_0000;
      end
      for (int i = 0; i < axis_cmd_pkg::PRE_COUNT; i++) begin
        preRegs_q[i] <= 32'h0000_0000;
      end
      ioBuf_q <= 32'h0000_0000;
      waitCnt_q <= 3'h0;
      waitRequest_n <= 1'b1;
    end else if (clkEn) begin
      wrRegs_q <= wrRegs_d;
      preRegs_q <= preRegs_d;
      ioBuf_q <= ioBuf_d;
      waitCnt_q <= waitCnt_d;
      // Taken from the next count so the pin drops on the same edge that takes the command.
      waitRequest_n <= waitCnt_d == axis_cmd_pkg::WAIT_ZERO;
    end
  end

  // Read data: a registered mux on the synchronised address; unmapped reads give zero.
  logic [7:0] rdData_d;

  always_comb begin
    rdData_d = busRdData;
    if (!sRead_n) begin
      if (sAddr == axis_cmd_pkg::ADDR_GPPORT) begin
        rdData_d = pinState;
      end else if (sAddr >= axis_cmd_pkg::ADDR_BUF0) begin
        rdData_d = ioBuf_q[8*(sAddr - axis_cmd_pkg::ADDR_BUF0) +: 8];
      end else begin
        rdData_d = 8'h00;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busRdData <= 8'h00;
    end else if (clkEn) begin
      busRdData <= rdData_d;
    end
  end

  // Only the low byte reaches the latch; the high byte is dropped here.
  gp_port_latch #(
    .PIN_COUNT(8)
  ) portLatch (
    .clk(clk),
    .reset_n(reset_n),
    .clkEn(clkEn),
    .pinMode(wrRegs_q[axis_cmd_pkg::IDX_PORT_CONFIG][15:0]),
    .groupWrite(groupWrite),
    .groupData(sData[7:0]),
    .bitWrite(bitWrite),
    .bitIndex(bitIndex),
    .bitValue(bitValue),
    .gpPinIn(gpPinIn),
    .gpPinOut(gpPinOut),
    .gpPinOe_n(gpPinOe_n),
    .pinState(pinState)
  );
endmodule

// [tb/axis_cmd_monitor.sv]
// Checker for the axis command port: wait request timing and output holding.
// Assumes clkEn stays high and the host leaves commands apart as required.
module axis_cmd_monitor #(
  parameter int CMD_WAIT = 4,
  parameter int PORT_WAIT = 2
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [2:0] busAddr,
  input wire logic busWrite_n,
  input wire logic busRead_n,
  input wire logic [7:0] busRdData,
  input wire logic waitRequest_n,
  input wire logic [7:0] gpPinOut,
  input wire logic [7:0] gpPinOe_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] lowCnt_d;
  logic [3:0] lowCnt_q;
  always_comb lowCnt_d = waitRequest_n ? 4'h0 : lowCnt_q + 4'h1;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) lowCnt_q <= 4'h0;
    else lowCnt_q <= lowCnt_d;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  AST_RESET_IDLE: assert property ($rose(reset_n) |-> gpPinOe_n == 8'hFF && waitRequest_n)
    else $error("outputs not idle after reset");
  AST_WAIT_MIN: assert property ($fell(waitRequest_n) |-> !waitRequest_n [*2])
    else $error("wait request too short");
  AST_WAIT_LEN: assert property ($rose(waitRequest_n) |-> lowCnt_q == PORT_WAIT || lowCnt_q == CMD_WAIT)
    else $error("wait request length wrong");
  AST_WAIT_MAX: assert property (lowCnt_q <= CMD_WAIT)
    else $error("wait request too long");
  AST_WAIT_CAUSE: assert property (busWrite_n [*5] ##0 waitRequest_n |=> waitRequest_n)
    else $error("wait request without a write");
  AST_RDATA_HOLD: assert property (busRead_n [*3] |=> $stable(busRdData))
    else $error("read data moved without a read");
  AST_PINS_HOLD: assert property (busWrite_n [*5] |=> $stable(gpPinOut))
    else $error("pin latch moved without a write");
  AST_OE_HOLD: assert property (busWrite_n [*5] |=> $stable(gpPinOe_n))
    else $error("pin enables moved without a write");
  AST_LATCH_KEPT: assert property ($changed(gpPinOe_n) |-> $stable(gpPinOut))
    else $error("pin latch lost on direction change");
  AST_CMD_READ_ZERO: assert property ((busAddr == 3'h0 && !busRead_n) [*4] |-> busRdData == 8'h00)
    else $error("command address read not zero");
  cover property ($rose(waitRequest_n) && lowCnt_q == PORT_WAIT);
  cover property ($rose(waitRequest_n) && lowCnt_q == CMD_WAIT);
  cover property ($changed(gpPinOut));
endmodule
bind axis_register_command_port axis_cmd_monitor #(.CMD_WAIT(CMD_WAIT), .PORT_WAIT(PORT_WAIT)) mon (
  .clk(clk), .reset_n(reset_n), .busAddr(busAddr), .busWrite_n(busWrite_n),
  .busRead_n(busRead_n), .busRdData(busRdData), .waitRequest_n(waitRequest_n),
  .gpPinOut(gpPinOut), .gpPinOe_n(gpPinOe_n));

// [tb/host_cpu_model.sv]
// Host CPU model driving strobed byte-bus writes and reads.
// Assumes callers never overlap tasks; every write spans twelve cycles.
module host_cpu_model (
  input wire logic clk,
  input wire logic waitRequest_n,
  input wire logic [7:0] busRdData,
  output logic [2:0] busAddr,
  output logic [15:0] busWrData,
  output logic busWrite_n,
  output logic busRead_n
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    busAddr = 3'h0;
    busWrData = 16'h0000;
    busWrite_n = 1'b1;
    busRead_n = 1'b1;
  end
  // Released lines show the inverse value so stale data can never pass as valid.
  task automatic wr(input logic [2:0] a, input logic [15:0] d, output int lows);
    lows = 0;
    @(posedge clk);
    #1;
    busAddr = a;
    busWrData = d;
    busWrite_n = 1'b0;
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      #1;
      if (i == 3) begin
        busWrite_n = 1'b1;
        busAddr = ~a;
        busWrData = ~d;
      end
      if (waitRequest_n === 1'b0) lows++;
    end
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    busAddr = a;
    busRead_n = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    d = busRdData;
    busRead_n = 1'b1;
    busAddr = ~a;
  endtask
endmodule

// [tb/tb.sv]
// Self-checking bench: register copies, read-only group, undefined codes, pin port.
// Assumes one reference clock and clkEn held high throughout.
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, reset_n, busWrite_n, busRead_n, waitRequest_n;
  logic [2:0] busAddr;
  logic [15:0] busWrData;
  logic [7:0] busRdData, gpPinOut, gpPinOe_n, gpIn, b;
  logic [351:0] roVals;
  logic [31:0] d;
  int bad_count = 0;
  int total_checks = 0;
  int n;
  logic [7:0] wc [6] = '{8'h90, 8'hAC, 8'hBC, 8'h80, 8'h8B, 8'h8C};
  logic [7:0] rc [6] = '{8'hD0, 8'hEC, 8'hFC, 8'hC0, 8'hCB, 8'hCC};
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  host_cpu_model host (.clk(clk), .waitRequest_n(waitRequest_n), .busRdData(busRdData),
    .busAddr(busAddr), .busWrData(busWrData), .busWrite_n(busWrite_n), .busRead_n(busRead_n));
  axis_register_command_port DUT (.clk(clk), .reset_n(reset_n), .clkEn(1'b1),
    .busAddr(busAddr), .busWrData(busWrData), .busWrite_n(busWrite_n), .busRead_n(busRead_n),
    .busRdData(busRdData), .waitRequest_n(waitRequest_n), .readOnlyValues(roVals),
    .gpPinIn(gpIn), .gpPinOut(gpPinOut), .gpPinOe_n(gpPinOe_n));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, seen);
      bad_count++;
    end
  endtask
  task automatic wreg(input logic [7:0] code, input logic [31:0] v);
    for (int i = 0; i < 4; i++) host.wr(3'h4 + 3'(i), {8'h00, v[8*i+:8]}, n);
    host.wr(3'h0, {8'h00, code}, n);
    chk(n, 4, "command wait");
  endtask
  task automatic rreg(input logic [7:0] code, output logic [31:0] v);
    host.wr(3'h0, {8'h00, code}, n);
    for (int i = 0; i < 4; i++) host.rd(3'h4 + 3'(i), v[8*i+:8]);
  endtask
  initial begin
    #200000;
    bad_count++;
    print_verdict();
  end
  initial begin
    reset_n = 1'b0;
    gpIn = 8'hC3;
    for (int k = 0; k < 11; k++) roVals[k*32+:32] = 32'h1234_5600 + 32'(k);
    repeat (3) @(posedge clk);
    #1;
    reset_n = 1'b1;
    chk(gpPinOe_n, 8'hFF, "reset enables");
    chk(waitRequest_n, 1'b1, "reset wait");
    for (int i = 0; i < 6; i++) wreg(wc[i], 32'hA5C3_0F10 ^ 32'(i));
    for (int i = 0; i < 6; i++) begin
      rreg(rc[i], d);
      chk(d, 32'hA5C3_0F10 ^ 32'(i), "register copy");
    end
    $display("register test done");
    rreg(8'hED, d);
    chk(d, 32'h1234_5600, "latched copy");
    rreg(8'hF5, d);
    chk(d, 32'h1234_5608, "speed monitor");
    rreg(8'hFF, d);
    chk(d, 32'h1234_560A, "interp status");
    $display("read-only test done");
    // An undefined code must leave both the buffer and the registers alone.
    wreg(8'hAD, 32'hDEAD_BEEF);
    for (int i = 0; i < 4; i++) host.rd(3'h4 + 3'(i), d[8*i+:8]);
    chk(d, 32'hDEAD_BEEF, "buffer after undefined");
    rreg(8'hD0, d);
    chk(d, 32'hA5C3_0F10, "register after undefined");
    rreg(8'hFC, d);
    chk(d, 32'hA5C3_0F12, "step count after undefined");
    $display("undefined code test done");
    wreg(8'h9D, 32'h0000_0055);
    chk(gpPinOe_n, 8'hF0, "pin enables");
    host.wr(3'h2, 16'hFFA5, n);
    chk(n, 2, "port wait");
    chk(gpPinOut, 8'h05, "group write");
    host.rd(3'h2, b);
    chk(b, 8'hC5, "pin readback");
    host.rd(3'h0, b);
    chk(b, 8'h00, "command address read");
    host.wr(3'h0, 16'h001B, n);
    host.wr(3'h0, 16'h0010, n);
    host.wr(3'h0, 16'h001F, n);
    chk(n, 4, "bit command wait");
    chk(gpPinOut, 8'h0C, "bit commands");
    wreg(8'h9D, 32'h0000_0000);
    chk(gpPinOe_n, 8'hFF, "all inputs");
    wreg(8'h9D, 32'h0000_0055);
    chk(gpPinOut, 8'h0C, "latch kept");
    $display("port test done");
    print_verdict();
  end
endmodule
